// ===== hdl/dmr_top.sv
// Control core of a stereo DAC: APB registers, serial control port, global and
// per-channel mute, gated attenuation, power-down/reset and rate tracking.
// Assumes pclk is the master clock and samples arrive on pclk.
// Function
// - Track frame rates from master clock over 1024 up to over 512.
// - Global mute pin high mutes left and right together.
// - A channel's register mute bit mutes only that channel.
// - Apply attenuation at zero crossing, or after 1024 samples regardless.
// - Power-down pin low holds low-power state; raising it resumes operation.
// - On release, clear all engine registers to zero.
// - Reset loads both channel control registers with defaults.
// - Control defaults are mute off and attenuation zero.
// - Control byte: bit 7 channel, bit 6 mute, bits 5..0 attenuation.
// - New attenuation arms on first frame edge after latch rise.
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module dmr_top #(
  parameter int unsigned RELOCK_CYCLES = dmr_pkg::RELOCK_CYCLES,
  parameter int unsigned ZC_TIMEOUT = dmr_pkg::ZC_TIMEOUT_SAMPLES
) (
  input wire logic pclk, // APB and master clock
  input wire logic presetn, // Async reset, active low
  input wire logic clk_en, // Clock enable, freezes all state when low
  input wire logic [dmr_pkg::ADDR_W-1:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic power_down_reset_n, // Power-down/reset pin, active low
  input wire logic mute_all, // Global mute pin
  input wire logic control_shift_clock, // Serial control clock pin
  input wire logic control_serial_in, // Serial control data pin
  input wire logic control_latch, // Serial control latch pin
  input wire logic frame_clock, // Left/right frame clock pin
  input wire logic input_port_mode_sel0, // Port mode select pin 0
  input wire logic input_port_mode_sel1, // Port mode select pin 1
  input wire logic word_len_18_sel, // Word length select pin
  input wire logic deemphasis_select, // De-emphasis select pin
  input wire logic sample_valid, // Sample pair strobe
  input wire logic [dmr_pkg::SAMPLE_W-1:0] sample_left, // Left sample
  input wire logic [dmr_pkg::SAMPLE_W-1:0] sample_right, // Right sample
  output logic power_down, // Power-down state
  output logic engine_clear, // One-cycle clear of the engine
  output logic ports_ready, // Relock wait over
  output logic rate_in_range, // Frame rate within tracking range
  output logic mute_left, // Effective left mute
  output logic mute_right, // Effective right mute
  output logic [dmr_pkg::ATT_W-1:0] atten_left, // Applied left attenuation
  output logic [dmr_pkg::ATT_W-1:0] atten_right, // Applied right attenuation
  output logic [1:0] port_mode, // Filtered port mode select
  output logic word_len_18, // Filtered word length select
  output logic deemph_en // Filtered de-emphasis select
);
  localparam int unsigned RLW = $clog2(RELOCK_CYCLES + 1);
  localparam logic [RLW-1:0] RELOCK_LAST = RLW'(RELOCK_CYCLES);
  localparam int unsigned RW = dmr_pkg::RATE_CNT_W;
  localparam logic [RW-1:0] RATE_MIN = RW'(dmr_pkg::RATE_DIV_MIN);
  localparam logic [RW-1:0] RATE_MAX = RW'(dmr_pkg::RATE_DIV_MAX);

  if (RELOCK_CYCLES < 1 || ZC_TIMEOUT < 2) begin : g_chk
    $error("dmr_top: RELOCK_CYCLES or ZC_TIMEOUT out of range");
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [dmr_pkg::PIN_N-1:0] pins;
  logic [dmr_pkg::PIN_N-1:0] pins_s;
  logic pdrst_s;
  logic mute_s;
  logic sclk_s;
  logic sdin_s;
  logic latch_s;
  logic frame_s;

  assign pins = {deemphasis_select, word_len_18_sel, input_port_mode_sel1,
                 input_port_mode_sel0, frame_clock, control_latch,
                 control_serial_in, control_shift_clock, mute_all,
                 power_down_reset_n};
  assign pdrst_s = pins_s[0];
  assign mute_s = pins_s[1];
  assign sclk_s = pins_s[2];
  assign sdin_s = pins_s[3];
  assign latch_s = pins_s[4];
  assign frame_s = pins_s[5];

  dmr_sync #(.W(dmr_pkg::PIN_N)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .ce(clk_en),
    .pin(pins),
    .q(pins_s)
  );

  // ****************************************
  // Power-down and release
  // ****************************************
  // Filter lag: a low pulse under two clocks may be missed
  logic pd_now;
  logic pd_q;
  logic release_q;
  logic clear_all;
  logic [RLW-1:0] relock_q;

  assign pd_now = ~pdrst_s;
  assign clear_all = pd_now | release_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_q <= 1'b1;
      release_q <= 1'b0;
      relock_q <= '0;
    end else if (clk_en) begin
      pd_q <= pd_now;
      release_q <= pd_q & ~pd_now;
      if (pd_now) begin
        relock_q <= '0;
      end else if (relock_q != RELOCK_LAST) begin
        relock_q <= relock_q + RLW'(1);
      end
    end
  end

  assign power_down = pd_q;
  assign engine_clear = release_q;
  assign ports_ready = (relock_q == RELOCK_LAST) & ~pd_q;

  // ****************************************
  // Frame clock edges and rate tracking
  // ****************************************
  logic frame_q;
  logic frame_edge;
  logic frame_rise;
  logic [RW-1:0] rate_cnt_q;
  logic [RW-1:0] period_q;
  logic rate_ok_q;
  logic [RW-1:0] rate_next;

  assign frame_edge = frame_s ^ frame_q;
  assign frame_rise = frame_s & ~frame_q;
  assign rate_next = (rate_cnt_q == '1) ? rate_cnt_q : rate_cnt_q + RW'(1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_q <= 1'b0;
      rate_cnt_q <= '0;
      period_q <= '0;
      rate_ok_q <= 1'b0;
    end else if (clk_en) begin
      frame_q <= frame_s;
      if (clear_all) begin
        rate_cnt_q <= '0;
        period_q <= '0;
        rate_ok_q <= 1'b0;
      end else if (frame_rise) begin
        rate_cnt_q <= '0;
        period_q <= rate_next;
        rate_ok_q <= (rate_next >= RATE_MIN) && (rate_next <= RATE_MAX);
      end else begin
        rate_cnt_q <= rate_next;
      end
    end
  end

  assign rate_in_range = rate_ok_q;

  // ****************************************
  // Serial control port
  // ****************************************
  logic sclk_q;
  logic latch_q;
  logic [7:0] shift_q;
  logic ser_wr;
  logic ser_wr_l;
  logic ser_wr_r;

  assign ser_wr = latch_s & ~latch_q;
  assign ser_wr_r = ser_wr & shift_q[dmr_pkg::CB_CHAN_BIT];
  assign ser_wr_l = ser_wr & ~shift_q[dmr_pkg::CB_CHAN_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q <= 1'b0;
      latch_q <= 1'b0;
      shift_q <= '0;
    end else if (clk_en) begin
      sclk_q <= sclk_s;
      latch_q <= latch_s;
      if (clear_all) begin
        shift_q <= '0;
      end else if (sclk_s & ~sclk_q) begin
        shift_q <= {shift_q[6:0], sdin_s};
      end
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  logic setup;
  logic wr_acc;
  logic hit_l;
  logic hit_r;
  logic hit_st;
  logic hit_rate;
  logic mapped;
  logic apb_wr_l;
  logic apb_wr_r;
  logic [31:0] rd_mux;
  logic [31:0] status_w;
  logic [31:0] prdata_q;
  logic pslverr_q;

  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign hit_l = (paddr == dmr_pkg::OFS_CTRL_LEFT);
  assign hit_r = (paddr == dmr_pkg::OFS_CTRL_RIGHT);
  assign hit_st = (paddr == dmr_pkg::OFS_STATUS);
  assign hit_rate = (paddr == dmr_pkg::OFS_RATE);
  assign mapped = hit_l | hit_r | hit_st | hit_rate;
  assign apb_wr_l = wr_acc & hit_l;
  assign apb_wr_r = wr_acc & hit_r;
  assign pready = clk_en;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  // ****************************************
  // Channel control registers
  // ****************************************
  logic [dmr_pkg::CTRL_W-1:0] ctrl_l_q;
  logic [dmr_pkg::CTRL_W-1:0] ctrl_r_q;
  logic [dmr_pkg::CTRL_W-1:0] ctrl_l_d;
  logic [dmr_pkg::CTRL_W-1:0] ctrl_r_d;
  logic wr_l;
  logic wr_r;

  // Bus write wins over a serial write landing in the same cycle
  assign wr_l = apb_wr_l | ser_wr_l;
  assign wr_r = apb_wr_r | ser_wr_r;
  assign ctrl_l_d = apb_wr_l ? pwdata[dmr_pkg::CTRL_W-1:0] : shift_q[dmr_pkg::CTRL_W-1:0];
  assign ctrl_r_d = apb_wr_r ? pwdata[dmr_pkg::CTRL_W-1:0] : shift_q[dmr_pkg::CTRL_W-1:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_l_q <= dmr_pkg::CTRL_RESET;
      ctrl_r_q <= dmr_pkg::CTRL_RESET;
    end else if (clk_en) begin
      if (clear_all) begin
        ctrl_l_q <= dmr_pkg::CTRL_RESET;
        ctrl_r_q <= dmr_pkg::CTRL_RESET;
      end else begin
        if (wr_l) begin
          ctrl_l_q <= ctrl_l_d;
        end
        if (wr_r) begin
          ctrl_r_q <= ctrl_r_d;
        end
      end
    end
  end

  // ****************************************
  // Channel attenuation updaters
  // ****************************************
  dmr_chan_if ch_l ();
  dmr_chan_if ch_r ();

  assign ch_l.wr = wr_l & ~clear_all;
  assign ch_l.wr_att = ctrl_l_d[dmr_pkg::ATT_W-1:0];
  assign ch_l.frame_edge = frame_edge;
  assign ch_l.frame_rise = frame_rise;
  assign ch_l.smp_valid = sample_valid;
  assign ch_l.smp = sample_left;
  assign ch_r.wr = wr_r & ~clear_all;
  assign ch_r.wr_att = ctrl_r_d[dmr_pkg::ATT_W-1:0];
  assign ch_r.frame_edge = frame_edge;
  assign ch_r.frame_rise = frame_rise;
  assign ch_r.smp_valid = sample_valid;
  assign ch_r.smp = sample_right;

  dmr_chan #(.TIMEOUT(ZC_TIMEOUT)) u_chan_l (
    .clk(pclk),
    .rst_n(presetn),
    .ce(clk_en),
    .clear(clear_all),
    .bus(ch_l)
  );

  dmr_chan #(.TIMEOUT(ZC_TIMEOUT)) u_chan_r (
    .clk(pclk),
    .rst_n(presetn),
    .ce(clk_en),
    .clear(clear_all),
    .bus(ch_r)
  );

  assign atten_left = ch_l.att_applied;
  assign atten_right = ch_r.att_applied;

  // ****************************************
  // Mute, mode outputs and read data
  // ****************************************
  logic mute_l_q;
  logic mute_r_q;
  logic [3:0] mode_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mute_l_q <= 1'b1;
      mute_r_q <= 1'b1;
      mode_q <= '0;
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else if (clk_en) begin
      // Hold muted through power-down to avoid clicks
      mute_l_q <= pd_now | mute_s | ctrl_l_q[dmr_pkg::CB_MUTE_BIT];
      mute_r_q <= pd_now | mute_s | ctrl_r_q[dmr_pkg::CB_MUTE_BIT];
      mode_q <= pins_s[9:6];
      if (setup) begin
        prdata_q <= rd_mux;
        pslverr_q <= ~mapped;
      end
    end
  end

  assign mute_left = mute_l_q;
  assign mute_right = mute_r_q;
  assign port_mode = mode_q[1:0];
  assign word_len_18 = mode_q[2];
  assign deemph_en = mode_q[3];

  always_comb begin
    status_w = '0;
    status_w[dmr_pkg::ST_PD] = pd_q;
    status_w[dmr_pkg::ST_READY] = ports_ready;
    status_w[dmr_pkg::ST_RATE_OK] = rate_ok_q;
    status_w[dmr_pkg::ST_MUTE_L] = mute_l_q;
    status_w[dmr_pkg::ST_MUTE_R] = mute_r_q;
    status_w[dmr_pkg::ST_PEND_L] = ch_l.pending;
    status_w[dmr_pkg::ST_PEND_R] = ch_r.pending;
    status_w[dmr_pkg::ST_MODE_LSB +: 2] = mode_q[1:0];
    status_w[dmr_pkg::ST_WL18] = mode_q[2];
    status_w[dmr_pkg::ST_DEEMPHASIS_SELECT] = mode_q[3];
    status_w[dmr_pkg::ST_ATT_L_LSB +: dmr_pkg::ATT_W] = ch_l.att_applied;
    status_w[dmr_pkg::ST_ATT_R_LSB +: dmr_pkg::ATT_W] = ch_r.att_applied;
  end

  assign rd_mux = hit_l ? 32'(ctrl_l_q) :
                  hit_r ? 32'(ctrl_r_q) :
                  hit_st ? status_w :
                  hit_rate ? 32'(period_q) : '0;

endmodule : dmr_top
`default_nettype wire

// ===== hdl/dmr_pkg.sv
// Constants for the DAC mute, attenuation and power-down control block.
// Assumes pclk, the master clock, runs at 125 MHz.
package dmr_pkg;

  // ********
  // Clock and timing
  // ********
  localparam int unsigned PCLK_HZ = 125_000_000;
  localparam int unsigned RELOCK_MS = 100;
  localparam int unsigned RELOCK_CYCLES = RELOCK_MS * (PCLK_HZ / 1000);
  localparam int unsigned RATE_DIV_MIN = 512;
  localparam int unsigned RATE_DIV_MAX = 1024;
  localparam int unsigned ZC_TIMEOUT_SAMPLES = 1024;
  localparam int unsigned RATE_CNT_W = 11;

  // ********
  // Widths and control byte layout
  // ********
  localparam int unsigned SAMPLE_W = 18;
  localparam int unsigned ATT_W = 6;
  localparam int unsigned CTRL_W = 7;
  localparam int unsigned CB_CHAN_BIT = 7;
  localparam int unsigned CB_MUTE_BIT = 6;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;

  // ********
  // Register offsets (byte addresses)
  // ********
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL_LEFT = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL_RIGHT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RATE = 8'h0C;

  // ********
  // Status register fields
  // ********
  localparam int unsigned ST_PD = 0;
  localparam int unsigned ST_READY = 1;
  localparam int unsigned ST_RATE_OK = 2;
  localparam int unsigned ST_MUTE_L = 3;
  localparam int unsigned ST_MUTE_R = 4;
  localparam int unsigned ST_PEND_L = 5;
  localparam int unsigned ST_PEND_R = 6;
  localparam int unsigned ST_MODE_LSB = 8;
  localparam int unsigned ST_WL18 = 10;
  localparam int unsigned ST_DEEMPHASIS_SELECT = 11;
  localparam int unsigned ST_ATT_L_LSB = 16;
  localparam int unsigned ST_ATT_R_LSB = 24;

  // Pin synchroniser lanes
  localparam int unsigned PIN_N = 10;

endpackage : dmr_pkg

// ===== hdl/dmr_chan_if.sv
// Carrier between the control core and one channel's attenuation updater.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface dmr_chan_if #(
  parameter int unsigned SAMPLE_W = dmr_pkg::SAMPLE_W,
  parameter int unsigned ATT_W = dmr_pkg::ATT_W
);
  logic wr;
  logic [ATT_W-1:0] wr_att;
  logic frame_edge;
  logic frame_rise;
  logic smp_valid;
  logic [SAMPLE_W-1:0] smp;
  logic [ATT_W-1:0] att_applied;
  logic pending;

  modport ctrl (
    output wr, wr_att, frame_edge, frame_rise, smp_valid, smp,
    input att_applied, pending
  );
  modport chan (
    input wr, wr_att, frame_edge, frame_rise, smp_valid, smp,
    output att_applied, pending
  );
endinterface : dmr_chan_if
`default_nettype wire

// ===== hdl/dmr_sync.sv
// Three-stage pin synchroniser; a lane changes once stages two and three agree.
// Assumes pin inputs are asynchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module dmr_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk, // Clock
  input wire logic rst_n, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire logic [W-1:0] pin, // Raw pins
  output logic [W-1:0] q // Filtered level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] agree;

  if (W < 1) begin : g_chk
    $error("dmr_sync: W must be at least 1");
  end

  // First stage feeds only the second
  assign agree = ~(s2_q ^ s3_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q <= '0;
    end else if (ce) begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q <= (agree & s3_q) | (~agree & q);
    end
  end
endmodule : dmr_sync
`default_nettype wire

// ===== hdl/dmr_chan.sv
// One channel's attenuation updater: arm on frame edge, apply on zero crossing
// or after a sample-count timeout. Assumes samples arrive on clk.
`timescale 1ns/1ns
`default_nettype none
module dmr_chan #(
  parameter int unsigned TIMEOUT = dmr_pkg::ZC_TIMEOUT_SAMPLES
) (
  input wire logic clk, // Clock
  input wire logic rst_n, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire logic clear, // Power-down or release clear
  dmr_chan_if.chan bus // Channel carrier
);
  typedef enum logic [1:0] {IDLE, ARM, SEEK} dmr_st_type;
  localparam int unsigned CW = $clog2(TIMEOUT + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(TIMEOUT - 1);

  dmr_st_type st_q;
  dmr_st_type st_d;
  logic [dmr_pkg::ATT_W-1:0] tgt_q;
  logic [dmr_pkg::ATT_W-1:0] tgt_d;
  logic [dmr_pkg::ATT_W-1:0] app_q;
  logic [dmr_pkg::ATT_W-1:0] app_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic sign_q;
  logic zero_cross;
  logic timed_out;

  if (TIMEOUT < 2) begin : g_chk
    $error("dmr_chan: TIMEOUT must be at least 2");
  end

  assign zero_cross = bus.smp_valid &&
    ((bus.smp == '0) || (bus.smp[dmr_pkg::SAMPLE_W-1] != sign_q));
  assign timed_out = bus.frame_rise && (cnt_q == CNT_LAST);
  assign bus.att_applied = app_q;
  assign bus.pending = (st_q != IDLE);

  always_comb begin
    st_d = st_q;
    tgt_d = tgt_q;
    app_d = app_q;
    cnt_d = cnt_q;
    if (bus.wr) begin
      // A fresh write restarts the wait so a coinciding edge never tears it
      tgt_d = bus.wr_att;
      st_d = ARM;
    end else begin
      unique case (st_q)
        IDLE: begin
        end
        ARM: begin
          if (bus.frame_edge) begin
            st_d = SEEK;
            cnt_d = '0;
          end
        end
        SEEK: begin
          if (zero_cross || timed_out) begin
            app_d = tgt_q;
            st_d = IDLE;
          end else if (bus.frame_rise) begin
            cnt_d = cnt_q + CW'(1);
          end
        end
        default: st_d = IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= IDLE;
      tgt_q <= '0;
      app_q <= '0;
      cnt_q <= '0;
      sign_q <= 1'b0;
    end else if (ce) begin
      if (clear) begin
        st_q <= IDLE;
        tgt_q <= '0;
        app_q <= '0;
        cnt_q <= '0;
        sign_q <= 1'b0;
      end else begin
        st_q <= st_d;
        tgt_q <= tgt_d;
        app_q <= app_d;
        cnt_q <= cnt_d;
        if (bus.smp_valid) begin
          sign_q <= bus.smp[dmr_pkg::SAMPLE_W-1];
        end
      end
    end
  end
endmodule : dmr_chan
`default_nettype wire

// ===== bench/dmr_top_sva.sv
// Checker for dmr_top: mute, power-down, clear and APB error relations.
// Assumes clk_en stays high; counts are in pclk cycles.
`timescale 1ns/1ns
`default_nettype none
module dmr_top_sva (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic [dmr_pkg::ADDR_W-1:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pslverr, // APB error
  input wire logic power_down_reset_n, // Power-down pin
  input wire logic mute_all, // Global mute pin
  input wire logic power_down, // Power-down state
  input wire logic engine_clear, // Clear pulse
  input wire logic mute_left, // Left mute
  input wire logic mute_right, // Right mute
  input wire logic [dmr_pkg::ATT_W-1:0] atten_left, // Left attenuation
  input wire logic [dmr_pkg::ATT_W-1:0] atten_right // Right attenuation
);
  // ********
  // Properties
  // ********
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C};
  // Eight cycles cover the pin filter and output register
  a_global_mute: assert property (mute_all [*8] |-> mute_left && mute_right)
    else $error("global mute missed a channel");
  a_pd_mutes: assert property (power_down |-> mute_left && mute_right)
    else $error("power-down left a channel unmuted");
  a_pd_entry: assert property (!power_down_reset_n [*8] |-> power_down)
    else $error("pin low did not enter power-down");
  a_pd_exit: assert property (power_down_reset_n [*8] |-> !power_down)
    else $error("pin high did not leave power-down");
  a_clear_edge: assert property (engine_clear |-> !power_down && $past(power_down))
    else $error("stray clear pulse");
  a_clear_fell: assert property ($fell(power_down) |-> engine_clear ##1 !engine_clear)
    else $error("release without a one-cycle clear");
  a_pd_zero: assert property (power_down [*2] |-> atten_left == '0 && atten_right == '0)
    else $error("attenuation not zero in power-down");
  a_unmapped_err: assert property (psel && penable |-> pslverr == !mapped)
    else $error("error flag wrong for address");
  c_clear: cover property (engine_clear);
  c_one_mute: cover property (mute_left && !mute_right);
  c_err: cover property (psel && penable && pslverr);
endmodule : dmr_top_sva
bind dmr_top dmr_top_sva u_sva (.pclk, .presetn, .paddr, .psel, .penable, .pslverr,
  .power_down_reset_n, .mute_all, .power_down, .engine_clear, .mute_left, .mute_right,
  .atten_left, .atten_right);
`default_nettype wire

// ===== bench/dmr_host.sv
// Host model: serial control port, free-running frame clock and sample strobes.
// Assumes the bench calls the tasks; drives follow rising edges.
`timescale 1ns/1ns
`default_nettype none
module dmr_host (
  input wire logic pclk, // Clock
  output logic control_shift_clock, // Serial control clock
  output logic control_serial_in, // Serial control data
  output logic control_latch, // Serial control latch
  output logic frame_clock, // Frame clock
  output logic sample_valid, // Sample strobe
  output logic [dmr_pkg::SAMPLE_W-1:0] sample_left, // Left sample
  output logic [dmr_pkg::SAMPLE_W-1:0] sample_right // Right sample
);
  // ********
  // Frame clock and port tasks
  // ********
  int half = 300;
  int fcnt = 0;
  initial begin
    {control_shift_clock, control_serial_in, control_latch, frame_clock, sample_valid} = '0;
    {sample_left, sample_right} = '0;
  end
  // Free-running: rate tracking needs it
  always @(posedge pclk) begin
    fcnt <= (fcnt >= half - 1) ? 0 : fcnt + 1;
    if (fcnt >= half - 1) frame_clock <= ~frame_clock;
  end
  // Six cycles per level clears the four-cycle pin filter
  task automatic send_ctl(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(posedge pclk);
      control_serial_in <= b[i];
      repeat (6) @(posedge pclk);
      control_shift_clock <= 1'b1;
      repeat (6) @(posedge pclk);
      control_shift_clock <= 1'b0;
    end
    repeat (6) @(posedge pclk);
    control_latch <= 1'b1;
    control_serial_in <= ~b[0];
    repeat (6) @(posedge pclk);
    control_latch <= 1'b0;
  endtask : send_ctl
  task automatic push(input logic [dmr_pkg::SAMPLE_W-1:0] l);
    @(posedge pclk);
    sample_valid <= 1'b1;
    sample_left <= l;
    sample_right <= '0;
    @(posedge pclk);
    sample_valid <= 1'b0;
    sample_left <= ~l;
    sample_right <= '1;
  endtask : push
endmodule : dmr_host
`default_nettype wire

// ===== bench/dmr_top_tb_top.sv
// Testbench for dmr_top: APB master, pin drives and host model calls.
// Assumes shortened relock and zero-crossing counts set below.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin num_errors++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
`define WAITC(c, n) for (int k = 0; k < (n) && !(c); k++) @(negedge pclk);
module dmr_top_tb_top;
  localparam int RELOCK = 50;
  localparam int ZCT = 4;
  logic pclk, presetn, clk_en, psel, penable, pwrite, power_down_reset_n, mute_all;
  logic input_port_mode_sel0, input_port_mode_sel1, word_len_18_sel, deemphasis_select;
  logic [dmr_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, power_down, engine_clear, ports_ready, rate_in_range;
  logic mute_left, mute_right, word_len_18, deemph_en;
  logic control_shift_clock, control_serial_in, control_latch, frame_clock, sample_valid;
  logic [dmr_pkg::SAMPLE_W-1:0] sample_left, sample_right;
  logic [dmr_pkg::ATT_W-1:0] atten_left, atten_right;
  logic [1:0] port_mode;
  int num_errors = 0;
  int tests_run = 0;
  int halves[4] = '{200, 256, 512, 520};
  dmr_top #(.RELOCK_CYCLES(RELOCK), .ZC_TIMEOUT(ZCT)) dut (.pclk, .presetn, .clk_en,
    .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .power_down_reset_n, .mute_all, .control_shift_clock, .control_serial_in,
    .control_latch, .frame_clock, .input_port_mode_sel0, .input_port_mode_sel1,
    .word_len_18_sel, .deemphasis_select, .sample_valid, .sample_left, .sample_right,
    .power_down, .engine_clear, .ports_ready, .rate_in_range, .mute_left, .mute_right,
    .atten_left, .atten_right, .port_mode, .word_len_18, .deemph_en);
  dmr_host u_host (.pclk, .control_shift_clock, .control_serial_in, .control_latch,
    .frame_clock, .sample_valid, .sample_left, .sample_right);
  // ********
  // Clock, tasks and tests
  // ********
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic close_out;
    $display("Counts: %0d run, %0d failed", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  task automatic cyc(input int n);
    repeat (n) @(negedge pclk);
  endtask : cyc
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] ex, input string nm);
    apb(1'b0, a, '0);
    `CHK(nm, ex, rd)
  endtask : rdchk
  // Tests take about 15k cycles
  initial begin
    repeat (40000) @(posedge pclk);
    num_errors++;
    $display("MISMATCH watchdog expected finish seen hang");
    close_out();
  end
  initial begin
    {presetn, psel, penable, pwrite, power_down_reset_n, mute_all} = '0;
    {input_port_mode_sel0, input_port_mode_sel1, word_len_18_sel, deemphasis_select} = '0;
    clk_en = 1'b1;
    paddr = '0;
    pwdata = '0;
    cyc(8);
    @(posedge pclk);
    presetn <= 1'b1;
    cyc(8);
    `CHK("pd_start", 1'b1, power_down)
    `CHK("mute_pd", 1'b1, mute_left)
    @(posedge pclk);
    power_down_reset_n <= 1'b1;
    `WAITC(engine_clear === 1'b1, 20)
    `CHK("clear", 1'b1, engine_clear)
    `WAITC(ports_ready === 1'b1, RELOCK + 10)
    `CHK("ready", 1'b1, ports_ready)
    rdchk(dmr_pkg::OFS_CTRL_LEFT, '0, "ctrl_l");
    rdchk(dmr_pkg::OFS_CTRL_RIGHT, '0, "ctrl_r");
    rdchk(8'h10, '0, "unmapped");
    `CHK("slverr", 1'b1, pslverr)
    `CHK("unmuted", 2'h0, {mute_left, mute_right})
    @(posedge pclk);
    mute_all <= 1'b1;
    cyc(8);
    `CHK("mute_all", 2'h3, {mute_left, mute_right})
    @(posedge pclk);
    mute_all <= 1'b0;
    apb(1'b1, dmr_pkg::OFS_CTRL_LEFT, 32'h0000_0040);
    cyc(8);
    `CHK("mute_own", 2'h2, {mute_left, mute_right})
    @(posedge frame_clock);
    cyc(20);
    apb(1'b1, dmr_pkg::OFS_CTRL_LEFT, 32'h0000_0003);
    u_host.push(18'h0_0010);
    u_host.push(18'h3_FFF0);
    cyc(3);
    `CHK("att_early", 6'h00, atten_left)
    @(frame_clock);
    cyc(10);
    u_host.push(18'h0_0010);
    cyc(3);
    `CHK("att_zc", 6'h03, atten_left)
    u_host.send_ctl(8'hC5);
    cyc(10);
    rdchk(dmr_pkg::OFS_CTRL_RIGHT, 32'h0000_0045, "ctrl_ser");
    `CHK("mute_ser", 2'h1, {mute_left, mute_right})
    cyc(1200);
    `CHK("att_wait", 6'h00, atten_right)
    `WAITC(atten_right === 6'h05, 2000)
    `CHK("att_timeout", 6'h05, atten_right)
    rdchk(dmr_pkg::OFS_RATE, 32'h0000_0258, "rate");
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      u_host.half <= halves[i];
      cyc(8 * halves[i]);
      `CHK("rate_ok", (i == 1 || i == 2), rate_in_range)
    end
    for (int m = 0; m < 4; m++) begin
      @(posedge pclk);
      {input_port_mode_sel1, input_port_mode_sel0} <= m[1:0];
      {word_len_18_sel, deemphasis_select} <= {m[0], m[1]};
      cyc(8);
      `CHK("modes", {m[1:0], m[0], m[1]}, {port_mode, word_len_18, deemph_en})
    end
    @(posedge pclk);
    power_down_reset_n <= 1'b0;
    cyc(8);
    `CHK("pd_again", 1'b1, power_down)
    `CHK("att_clr", 12'h000, {atten_left, atten_right})
    @(posedge pclk);
    power_down_reset_n <= 1'b1;
    `WAITC(ports_ready === 1'b1, RELOCK + 20)
    rdchk(dmr_pkg::OFS_CTRL_RIGHT, '0, "ctrl_def");
    `CHK("unmute_def", 2'h0, {mute_left, mute_right})
    close_out();
  end
endmodule : dmr_top_tb_top
`undef CHK
`undef WAITC
`default_nettype wire
